// file: rtl/scg_pkg.sv
// package for the spreading code generator and acquisition block
// used by the code generator end; the correlator end does not import it
package scg_pkg;

  // code families selected by the controller
  typedef enum logic [1:0] {
    SCG_GOLD,
    SCG_MAXLEN,
    SCG_BARKER,
    SCG_NAV
  } scg_family_type;

  localparam int SCG_POLY_W = 24;           // polynomial field width
  localparam int SCG_LEN_W  = 24;           // register length / counter width
  localparam int SCG_SF_W   = 18;           // spreading factor width
  localparam int SCG_SAT_W  = 6;            // satellite identifier width
  localparam int SCG_WIN_W  = 16;           // lock window width
  localparam int SCG_LOOP_RESET_BIT = 7;    // loop reset bit position

  localparam logic [10:0] SCG_BARKER11 = 11'h5b8;
  localparam logic [12:0] SCG_BARKER13 = 13'h1f35;
  localparam logic [4:0]  SCG_LEN11    = 5'h0b;
  localparam logic [4:0]  SCG_LEN13    = 5'h0d;

  localparam int SCG_NAV_N = 10;             // navigation register length
  localparam logic [SCG_POLY_W-1:0] SCG_NAV_G1 = 24'h000204; // 1+x^3+x^10
  localparam logic [SCG_POLY_W-1:0] SCG_NAV_G2 = 24'h0003a6; // 1+x2+x3+x6+x8+x9+x10
  localparam logic [SCG_SF_W-1:0]   SCG_NAV_LEN = 18'h003ff; // 1023 chips

  // navigation output taps, tap a in [7:4], tap b in [3:0], index = id-1
  localparam logic [7:0] SCG_NAV_TAPS [0:36] = '{
    8'h26, 8'h37, 8'h48, 8'h59, 8'h19, 8'h2a, 8'h18, 8'h29, 8'h3a, 8'h23,
    8'h34, 8'h56, 8'h67, 8'h78, 8'h89, 8'h9a, 8'h14, 8'h25, 8'h36, 8'h47,
    8'h58, 8'h69, 8'h13, 8'h46, 8'h57, 8'h68, 8'h79, 8'h8a, 8'h16, 8'h27,
    8'h38, 8'h49, 8'h5a, 8'h4a, 8'h17, 8'h28, 8'h4a
  };

  localparam logic [15:0] SCG_DLL_GAIN_SHIFT = 16'h0004; // loop step divisor exponent
  localparam logic [15:0] SCG_CHIP_DIV_RST   = 16'h0000; // chip divider reset value

endpackage

// file: rtl/scg_link_if.sv
// link between code generator and correlator / lock detector
// one clock, both ends synchronous to it
`timescale 1ns/1ps
`default_nettype none
interface scg_link_if;
  logic        chip_en;       // one pulse per chip
  logic        code_chip;     // replica chip for I and Q
  logic        period_start;  // first chip of a code period
  logic        bit_strobe;    // one pulse per demodulated bit
  logic        code_lock;     // lock detector verdict
  logic signed [7:0] dll_err; // early minus late, updated the cycle after bit_strobe
  logic        acquiring;     // sweep is running
  logic        slip;          // sweep step pulse

  modport gen (output chip_en, code_chip, period_start, bit_strobe, acquiring, slip,
               input code_lock, dll_err);
  modport cor (input chip_en, code_chip, period_start, bit_strobe, acquiring, slip,
               output code_lock, dll_err);
endinterface
`default_nettype wire

// file: rtl/scg_code_gen.sv
// code replica generator, acquisition sweep and first order code loop
// assumes one 50 MHz clock and a correlator end on scg_link_if
//
// Functional notes
// RULE_01: one replica feeds both I and Q
// RULE_02: gold codes use two programmable shift registers
// RULE_03: register code period is 2^n-1 chips
// RULE_04: registers reload all ones each period
// RULE_05: registers never reach the all zero state
// RULE_06: software programs both generator polynomials
// RULE_07: maximal length uses first register only
// RULE_08: fixed 11 and 13 chip patterns selectable
// RULE_09: software sets length 11 or 13
// RULE_10: navigation code uses fixed 1023 chip polynomials
// RULE_11: navigation second output xors satellite taps
// RULE_12: quadrature bit rate twice chip rate per period
// RULE_13: acquisition starts after lock window without lock
// RULE_14: sweep slips one chip per lock window
// RULE_15: sweep stops at once on code lock
// RULE_16: software supplies the lock window count
// RULE_17: first order loop tracks code after lock
// RULE_18: software writes bit 7 to clear loops
// RULE_19: loop reset is self clearing, returns acquisition
// RULE_20: lock indicator high locked, low scanning
// RULE_21: polynomial bit k-1 is x^k coefficient
// RULE_22: gold chip xors both register outputs
// RULE_23: fixed patterns emitted msb first
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module scg_code_gen (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset,
  // software register port
  input  wire logic [3:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  // code lock indicator
  output logic                               code_locked,
  // link to correlator
  scg_link_if.gen                            link
);

  localparam logic [3:0] A_CTRL  = 4'h0; // family, qpsk, satellite
  localparam logic [3:0] A_POLY1 = 4'h1;
  localparam logic [3:0] A_POLY2 = 4'h2;
  localparam logic [3:0] A_LEN   = 4'h3; // register length n / spreading factor
  localparam logic [3:0] A_DIV   = 4'h4; // clocks per chip minus one
  localparam logic [3:0] A_WIN   = 4'h5; // lock window in bits
  localparam logic [3:0] A_LOOP  = 4'h6; // loop control, bit 7 reset
  localparam logic [3:0] A_STAT  = 4'h7; // status

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  scg_pkg::scg_family_type           family_r;
  logic                              qpsk_r;
  logic [scg_pkg::SCG_SAT_W-1:0]     sat_r;
  logic [scg_pkg::SCG_POLY_W-1:0]    poly1_r, poly2_r;
  logic [4:0]                        nlen_r;
  logic [scg_pkg::SCG_SF_W-1:0]      sf_r;
  logic [15:0]                       div_r;
  logic [scg_pkg::SCG_WIN_W-1:0]     win_r;
  logic                              loop_rst;

  wire wr_ctrl = reg_wr && reg_addr == A_CTRL;
  wire wr_loop = reg_wr && reg_addr == A_LOOP;
  assign loop_rst = wr_loop && reg_wdata[scg_pkg::SCG_LOOP_RESET_BIT]; // [RULE_18] [RULE_19]

  // software writes
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      family_r <= scg_pkg::SCG_GOLD;
      qpsk_r   <= 1'b0;
      sat_r    <= 6'h01;
      poly1_r  <= 24'h000012;
      poly2_r  <= 24'h00001b;
      nlen_r   <= 5'h05;
      sf_r     <= 18'h0001f;
      div_r    <= 16'h0003;
      win_r    <= 16'h0010;
    end
    else if (reg_wr)
    begin
      if (wr_ctrl)
      begin
        family_r <= scg_pkg::scg_family_type'(reg_wdata[1:0]);
        qpsk_r   <= reg_wdata[2];
        sat_r    <= reg_wdata[13:8];
      end
      if (reg_addr == A_POLY1) poly1_r <= reg_wdata[23:0]; // [RULE_06]
      if (reg_addr == A_POLY2) poly2_r <= reg_wdata[23:0]; // [RULE_06]
      if (reg_addr == A_LEN)
      begin
        nlen_r <= reg_wdata[4:0];
        sf_r   <= reg_wdata[25:8]; // [RULE_09]
      end
      if (reg_addr == A_DIV) div_r <= reg_wdata[15:0];
      if (reg_addr == A_WIN) win_r <= reg_wdata[15:0]; // [RULE_16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chip rate divider with code loop correction
  logic [15:0] div_cnt_r;
  logic signed [15:0] dll_acc_r;
  logic        hold_r;      // skip one chip (slip)
  wire   chip_tick = div_cnt_r == 16'h0000;
  assign link.chip_en = chip_tick && !hold_r;

  // code length in chips for the active family
  wire is_nav    = family_r == scg_pkg::SCG_NAV;
  wire is_barker = family_r == scg_pkg::SCG_BARKER;
  wire [scg_pkg::SCG_SF_W-1:0] reg_period = (18'h00001 << nlen_r) - 18'h00001; // [RULE_03]
  wire [scg_pkg::SCG_SF_W-1:0] period = is_nav ? scg_pkg::SCG_NAV_LEN :         // [RULE_10]
                                        is_barker ? sf_r : reg_period;

  ////////////////////////////////////////////////////////////////////////////
  // shift registers, fibonacci form; bit k-1 of a polynomial is x^k
  logic [scg_pkg::SCG_POLY_W-1:0] sr1_r, sr2_r; // first and second code shift registers
  logic [scg_pkg::SCG_SF_W-1:0]   chip_cnt_r;
  wire [scg_pkg::SCG_POLY_W-1:0] p1 = is_nav ? scg_pkg::SCG_NAV_G1 : poly1_r;
  wire [scg_pkg::SCG_POLY_W-1:0] p2 = is_nav ? scg_pkg::SCG_NAV_G2 : poly2_r;
  wire [4:0] n_act = is_nav ? 5'h0a : nlen_r;
  wire fb1 = ^(sr1_r & p1); // [RULE_21]
  wire fb2 = ^(sr2_r & p2); // [RULE_21]
  wire out1 = sr1_r[n_act - 5'h01];
  wire out2 = sr2_r[n_act - 5'h01];
  wire [7:0] taps = scg_pkg::SCG_NAV_TAPS[(sat_r == 6'h00 || sat_r > 6'h25) ? 6'h00 :
                                          sat_r - 6'h01];
  wire nav2 = sr2_r[taps[7:4] - 4'h1] ^ sr2_r[taps[3:0] - 4'h1]; // [RULE_11]
  wire all_ones_sel = 1'b1;
  wire [12:0] barker = (sf_r == 18'h0000b) ? {2'b00, scg_pkg::SCG_BARKER11}
                                           : scg_pkg::SCG_BARKER13;
  wire bark_chip = barker[sf_r[3:0] - 4'h1 - chip_cnt_r[3:0]]; // [RULE_08] [RULE_23]
  logic chip_sel;
  always_comb
  begin
    case (family_r)
      scg_pkg::SCG_GOLD:   chip_sel = out1 ^ out2;     // [RULE_22] [RULE_02]
      scg_pkg::SCG_MAXLEN: chip_sel = out1;            // [RULE_07]
      scg_pkg::SCG_BARKER: chip_sel = bark_chip;
      scg_pkg::SCG_NAV:    chip_sel = out1 ^ nav2;
      default:             chip_sel = out1;
    endcase
  end
  wire last_chip = chip_cnt_r == period - 18'h00001;
  // shift-in pattern with the all ones load; register bits above n are ignored
  wire [scg_pkg::SCG_POLY_W-1:0] ones = {scg_pkg::SCG_POLY_W{all_ones_sel}};

  // code generator advances once per chip
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sr1_r          <= 24'hffffff;
      sr2_r          <= 24'hffffff;
      chip_cnt_r     <= 18'h00000;
      link.code_chip <= 1'b0;
      link.period_start <= 1'b0;
    end
    else if (wr_ctrl || loop_rst)
    begin
      sr1_r      <= ones;
      sr2_r      <= ones;
      chip_cnt_r <= 18'h00000;
      link.period_start <= 1'b0;
    end
    else if (link.chip_en)
    begin
      link.code_chip    <= chip_sel;               // [RULE_01]
      link.period_start <= chip_cnt_r == 18'h00000;
      if (last_chip)
      begin
        sr1_r      <= ones;                        // [RULE_04] [RULE_05]
        sr2_r      <= ones;
        chip_cnt_r <= 18'h00000;
      end
      else
      begin
        sr1_r      <= {sr1_r[22:0], fb1};          // [RULE_05]
        sr2_r      <= {sr2_r[22:0], fb2};
        chip_cnt_r <= chip_cnt_r + 18'h00001;
      end
    end
    else
      link.period_start <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit strobe: one per period, two for quadrature
  logic [scg_pkg::SCG_SF_W-1:0] half;
  assign half = {1'b0, period[scg_pkg::SCG_SF_W-1:1]};
  assign link.bit_strobe = link.chip_en &&
    (last_chip || (qpsk_r && chip_cnt_r == half - 18'h00001)); // [RULE_12]

  ////////////////////////////////////////////////////////////////////////////
  // acquisition state machine
  typedef enum logic [1:0] {ST_ACQ, ST_TRACK} scg_acq_type;
  scg_acq_type st_r;
  logic [scg_pkg::SCG_WIN_W-1:0] bit_cnt_r;
  wire win_done = link.bit_strobe && bit_cnt_r >= win_r - 16'h0001;
  assign link.acquiring = st_r == ST_ACQ;
  assign link.slip = st_r == ST_ACQ && !link.code_lock && win_done;  // [RULE_14]
  assign code_locked = st_r == ST_TRACK;                             // [RULE_20]

  // lock and sweep control
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      st_r      <= ST_ACQ;
      bit_cnt_r <= 16'h0000;
    end
    else if (loop_rst)
    begin
      st_r      <= ST_ACQ;                                           // [RULE_19]
      bit_cnt_r <= 16'h0000;
    end
    else
    begin
      case (st_r)
        ST_ACQ:
        begin
          if (link.code_lock)
          begin
            st_r      <= ST_TRACK;                                   // [RULE_15]
            bit_cnt_r <= 16'h0000;
          end
          else if (link.bit_strobe)
            bit_cnt_r <= win_done ? 16'h0000 : bit_cnt_r + 16'h0001;
        end
        ST_TRACK:
        begin
          if (link.code_lock)
            bit_cnt_r <= 16'h0000;
          else if (win_done)
          begin
            st_r      <= ST_ACQ;                                     // [RULE_13]
            bit_cnt_r <= 16'h0000;
          end
          else if (link.bit_strobe)
            bit_cnt_r <= bit_cnt_r + 16'h0001;
        end
        default: st_r <= ST_ACQ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chip divider: slip holds one chip, loop accumulator trims one clock
  wire dll_step = st_r == ST_TRACK && link.bit_strobe;
  wire signed [15:0] acc_nxt = dll_acc_r + 16'(link.dll_err);
  wire adv = acc_nxt > 16'sh0010;
  wire ret = acc_nxt < -16'sh0010;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      div_cnt_r <= scg_pkg::SCG_CHIP_DIV_RST;
      dll_acc_r <= 16'sh0000;
      hold_r    <= 1'b0;
    end
    else
    begin
      if (loop_rst)
        dll_acc_r <= 16'sh0000;                                      // [RULE_19]
      else if (dll_step)                                             // [RULE_17]
        dll_acc_r <= (adv || ret) ? 16'sh0000 : acc_nxt;
      if (link.slip)
        hold_r <= 1'b1;                                              // [RULE_14]
      else if (chip_tick)
        hold_r <= 1'b0;
      // a loop step always falls on a chip tick, so the trim goes into the reload
      if (chip_tick && dll_step && adv && div_r != 16'h0000)
        div_cnt_r <= div_r - 16'h0001;                               // [RULE_17]
      else if (chip_tick && dll_step && ret)
        div_cnt_r <= div_r + 16'h0001;                               // [RULE_17]
      else if (chip_tick)
        div_cnt_r <= div_r;
      else
        div_cnt_r <= div_cnt_r - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back, data one cycle after the strobe
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        A_CTRL:  reg_rdata <= {18'h00000, sat_r, 5'h00, qpsk_r, family_r};
        A_POLY1: reg_rdata <= {8'h00, poly1_r};
        A_POLY2: reg_rdata <= {8'h00, poly2_r};
        A_LEN:   reg_rdata <= {6'h00, sf_r, 3'h0, nlen_r};
        A_DIV:   reg_rdata <= {16'h0000, div_r};
        A_WIN:   reg_rdata <= {16'h0000, win_r};
        A_STAT:  reg_rdata <= {14'h0000, chip_cnt_r[15:0], 1'b0, code_locked};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: rtl/scg_correlator.sv
// correlator end: despreads early, prompt and late samples against the replica and judges lock
// assumes user samples synchronous to clock, one per chip at most
`timescale 1ns/1ps
`default_nettype none
module scg_correlator (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // user samples, early / prompt / late soft chips
  input  wire logic signed [7:0] prompt_in,
  input  wire logic signed [7:0] early_in,
  input  wire logic signed [7:0] late_in,
  input  wire logic [15:0]       lock_thresh,
  // results
  output logic signed [15:0]     despread_out,
  output logic                   despread_valid,
  // link to generator
  scg_link_if.cor                link
);

  logic signed [15:0] acc_p_r, acc_e_r, acc_l_r;
  wire signed [15:0] p = link.code_chip ? 16'(prompt_in) : -16'(prompt_in); // same chip I and Q
  wire signed [15:0] e = link.code_chip ? 16'(early_in)  : -16'(early_in);
  wire signed [15:0] l = link.code_chip ? 16'(late_in)   : -16'(late_in);
  wire signed [15:0] pa = acc_p_r + p;
  wire signed [15:0] mag = pa < 0 ? -pa : pa;
  wire signed [15:0] ea = acc_e_r + e;
  wire signed [15:0] la = acc_l_r + l;
  wire signed [15:0] em = ea < 0 ? -ea : ea;
  wire signed [15:0] lm = la < 0 ? -la : la;
  wire signed [15:0] diff = em - lm;

  // integrate and dump per bit, lock verdict and loop error
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      acc_p_r <= 16'sh0000;
      acc_e_r <= 16'sh0000;
      acc_l_r <= 16'sh0000;
      despread_out   <= 16'sh0000;
      despread_valid <= 1'b0;
      link.code_lock <= 1'b0;
      link.dll_err   <= 8'sh00;
    end
    else
    begin
      despread_valid <= 1'b0;
      if (link.chip_en && link.bit_strobe)
      begin
        acc_p_r <= 16'sh0000;
        acc_e_r <= 16'sh0000;
        acc_l_r <= 16'sh0000;
        despread_out   <= pa;
        despread_valid <= 1'b1;
        link.code_lock <= mag >= $signed(lock_thresh);
        link.dll_err   <= diff[15:8];
      end
      else if (link.chip_en)
      begin
        acc_p_r <= pa;
        acc_e_r <= ea;
        acc_l_r <= la;
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/scg_monitor.sv
// checker on the link joining the code generator and the correlator
// assumes one clock domain, reset asynchronous and active high
`timescale 1ns/1ps
`default_nettype none
module scg_monitor (
  // clock and reset
  input wire logic              clock,
  input wire logic              reset,
  // link signals
  input wire logic              chip_en,
  input wire logic              code_chip,
  input wire logic              period_start,
  input wire logic              bit_strobe,
  input wire logic              code_lock,
  input wire logic signed [7:0] dll_err,
  input wire logic              acquiring,
  input wire logic              slip
);
  // all checks share the one clock and its reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  // timing of chips, bits and periods
  property p_bit_on_chip; bit_strobe |-> chip_en; endproperty
  a_bit_on_chip: assert property (p_bit_on_chip) else $error("bit strobe off chip");
  property p_start_pulse; period_start |=> !period_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("period start too long");
  //////////////////////////////////////////////////////////////////////////////
  // sweep, lock and loop error
  property p_slip_in_acq; slip |-> acquiring && !code_lock; endproperty
  a_slip_in_acq: assert property (p_slip_in_acq) else $error("slip outside search");
  property p_slip_pulse; slip |=> !slip; endproperty
  a_slip_pulse: assert property (p_slip_pulse) else $error("slip held too long");
  property p_lock_halts; $rose(code_lock) |-> ##[0:3] !acquiring; endproperty
  a_lock_halts: assert property (p_lock_halts) else $error("sweep runs on after lock");
  property p_leave_on_lock; $fell(acquiring) |-> code_lock || $past(code_lock); endproperty
  a_leave_on_lock: assert property (p_leave_on_lock) else $error("search left unlocked");
  property p_err_on_bit; $changed(dll_err) |-> $past(bit_strobe); endproperty
  a_err_on_bit: assert property (p_err_on_bit) else $error("loop error off bit");
  property p_lock_on_bit; $changed(code_lock) |-> $past(bit_strobe); endproperty
  a_lock_on_bit: assert property (p_lock_on_bit) else $error("lock change off bit");
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench: code generator and correlator joined over the link
// assumes scg_pkg, the link interface and both design ends compile first
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  // clock, reset and register port
  logic               clock;
  logic               reset;
  logic        [3:0]  reg_addr;
  logic        [31:0] reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic        [31:0] reg_rdata;
  logic               code_locked;
  // correlator user side
  logic signed [7:0]  prompt_in;
  logic signed [15:0] despread_out;
  logic               despread_valid;
  // bench state
  int                 fail_count;
  int                 n_checks;
  int                 k1;
  int                 k2;
  int                 nbits;
  logic               follow;
  logic        [31:0] rv;
  logic        [12:0] pat;
  logic               chips [0:4095];
  logic               saved [0:1022];
  //////////////////////////////////////////////////////////////////////////////
  // both ends face each other across the link
  scg_link_if link ();
  scg_code_gen scg_code_gen_inst (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .code_locked(code_locked), .link(link));
  scg_correlator scg_correlator_inst (.clock(clock), .reset(reset), .prompt_in(prompt_in),
    .early_in(prompt_in), .late_in(8'sh00), .lock_thresh(16'h0200), .despread_out(despread_out),
    .despread_valid(despread_valid), .link(link));
  scg_monitor scg_monitor_inst (.clock(clock), .reset(reset), .chip_en(link.chip_en),
    .code_chip(link.code_chip), .period_start(link.period_start), .bit_strobe(link.bit_strobe),
    .code_lock(link.code_lock), .dll_err(link.dll_err), .acquiring(link.acquiring),
    .slip(link.slip));
  //////////////////////////////////////////////////////////////////////////////
  // clock, and a received signal that copies the replica while follow is set
  initial clock = 1'b0;
  always #10 clock = ~clock;
  always @(posedge clock)
  begin
    prompt_in <= follow ? (link.code_chip ? 8'sh64 : 8'sh9c) : 8'sh00;
  end
  // register port cycles, one idle cycle after each strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
  // bounded wait for a link level: 0 lock, 1 search, 2 slip
  function automatic logic sig(input int w);
    return (w == 0) ? link.code_lock : (w == 1) ? link.acquiring : link.slip;
  endfunction
  task automatic wait_sig(input int w, input logic v);
    int t;
    t = 0;
    while (sig(w) !== v && t < 8000)
    begin
      @(posedge clock);
      #1;
      t++;
    end
    `CHECK(sig(w), v)
  endtask
  // record two code periods chip by chip from a period start
  task automatic grab();
    int   t;
    int   k;
    logic ce;
    logic bs;
    t = 0;
    k = 0;
    k1 = 0;
    k2 = 0;
    nbits = 0;
    while (link.period_start !== 1'b1 && t < 9000)
    begin
      @(posedge clock);
      #1;
      t++;
    end
    chips[0] = link.code_chip;
    while (k2 == 0 && t < 9000)
    begin
      @(posedge clock);
      ce = link.chip_en;
      bs = link.bit_strobe;
      #1;
      t++;
      if (ce === 1'b1 && k < 4095) k++;
      if (ce === 1'b1) chips[k] = link.code_chip;
      if (bs === 1'b1 && k1 == 0) nbits++;
      if (link.period_start === 1'b1 && k1 != 0) k2 = k;
      if (link.period_start === 1'b1 && k1 == 0) k1 = k;
    end
  endtask
  // select a code, then check period, bits per period and repetition
  task automatic run(input logic [31:0] ctrl, input logic [31:0] len, input int per,
                     input int bits);
    wr(4'h3, len);
    wr(4'h0, ctrl);
    grab();
    `CHECK(k1, per)
    `CHECK(k2, 2 * per)
    `CHECK(nbits, bits)
    for (int i = 0; i < per; i++) `CHECK(chips[i + per], chips[i])
  endtask
  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #1500000;
    fail_count++;
    report_and_stop();
  end
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    follow = 1'b0;
    prompt_in = 8'sh00;
    fail_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clock);
    `CHECK(code_locked, 1'b0)
    `CHECK(reg_rdata, 32'h0)
    reset <= 1'b0;
    @(posedge clock);
    // unmapped read, then a wide window so no sweep disturbs the codes
    rd(4'hf, rv);
    `CHECK(rv, 32'h0)
    wr(4'h5, 32'h0000ffff);
    wr(4'h4, 32'h1);
    wr(4'h1, 32'h12);
    wr(4'h2, 32'h1b);
    run(32'h0, 32'h1f05, 31, 1);
    wr(4'h1, 32'h9);
    run(32'h5, 32'h0f04, 15, 2);
    nbits = 0;
    for (int i = 0; i < 15; i++) nbits += chips[i];
    `CHECK(nbits, 8)
    run(32'h2, 32'h0b00, 11, 1);
    pat = 13'h05b8;
    for (int i = 0; i < 11; i++) `CHECK(chips[i], pat[10 - i])
    run(32'h6, 32'h0d00, 13, 2);
    pat = 13'h1f35;
    for (int i = 0; i < 13; i++) `CHECK(chips[i], pat[12 - i])
    run(32'h0103, 32'h3ff0a, 1023, 1);
    for (int i = 0; i < 1023; i++) saved[i] = chips[i];
    run(32'h1703, 32'h3ff0a, 1023, 1);
    nbits = 0;
    for (int i = 0; i < 1023; i++) nbits += (saved[i] != chips[i]);
    `CHECK(nbits > 0, 1'b1)
    // lock on the copied replica, loop reset, relock, then loss of signal
    wr(4'h4, 32'h3);
    wr(4'h3, 32'h0f04);
    wr(4'h0, 32'h1);
    wr(4'h5, 32'h2);
    follow <= 1'b1;
    wait_sig(0, 1'b1);
    wait_sig(1, 1'b0);
    `CHECK(code_locked, 1'b1)
    rd(4'h7, rv);
    `CHECK(rv[0], 1'b1)
    reg_addr <= 4'h6;
    reg_wdata <= 32'h80;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
    `CHECK(link.acquiring, 1'b1)
    `CHECK(code_locked, 1'b0)
    @(posedge clock);
    rd(4'h6, rv);
    `CHECK(rv[7], 1'b0)
    wait_sig(1, 1'b0);
    // two full bits after the restart: 15 aligned chips of 100 each
    repeat (2) @(posedge despread_valid);
    #1;
    `CHECK(despread_out, 16'h05dc)
    follow <= 1'b0;
    wait_sig(0, 1'b0);
    `CHECK(link.acquiring, 1'b0)
    wait_sig(1, 1'b1);
    `CHECK(code_locked, 1'b0)
    wait_sig(2, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
